// ---- src/tca_params.svh ----
/*
 * Constants for the accumulator arithmetic datapath.
 * Assumes inclusion by bare name from the datapath sources.
 */
`ifndef TCA_PARAMS_SVH
`define TCA_PARAMS_SVH

`define TCA_WIDTH     16
`define TCA_SIGN_BIT  15
`define TCA_ACC_RST   16'h0000
`define TCA_EXT_RST   1'h0
`define TCA_OVF_RST   1'h0
`define TCA_ONE       16'h0001

`endif

// ---- src/tca_pkg.sv ----
/*
 * Types for the accumulator arithmetic datapath.
 * Assumes the params header is on the include path.
 */
`include "tca_params.svh"

package tca_pkg;

  // Operations requested by the instruction decoder
  typedef enum logic [2:0] {
    TCA_OP_NONE,
    TCA_OP_LOAD,
    TCA_OP_ADD,
    TCA_OP_INVERT_ACCUMULATOR,
    TCA_OP_CLEAR_THEN_INVERT_ACCUMULATOR,
    TCA_OP_INCREMENT,
    TCA_OP_INVERT_CARRY_BIT,
    TCA_OP_CLEAR_THEN_INVERT_CARRY_BIT
  } tca_op_t;

  // One request from the decoder
  typedef struct packed {
    logic                    valid;
    tca_op_t                 op;
    logic [`TCA_WIDTH-1:0]   operand;
  } tca_req_t;

  // Visible datapath state
  typedef struct packed {
    logic [`TCA_WIDTH-1:0]   acc;
    logic                    carry;
    logic                    overflow;
    logic                    negative;
  } tca_stat_t;

endpackage

// ---- src/tca_datapath.sv ----
/*
 * Accumulator arithmetic datapath: 16-bit accumulator, one-bit extend
 * register, add, increment and complement operations.
 * Assumes one clock, synchronous reset, and a decoder that presents one
 * request per cycle; no register bus.
 * Extend is sticky: an add or increment only sets it, and it is cleared
 * by reset or by a complement. Overflow is kept until the next add or
 * increment. Widths and reset values come from the params header.
 */
// Behaviour
// - Only binary addition exists; subtract, multiply, divide are done by program.
// - Excess carry beyond register width goes to the extend bit; register holds true difference.
// - Complementing accumulator or extend bit inverts every bit of it.
// - Increment after one's complement gives the two's complement negation.
// - A value is negative when bit 15 is one.
// - Sign bit is an ordinary data bit in every addition.
// - Result is 16 bits; carry out of bit 15 goes to the extend bit.
`include "tca_params.svh"
`timescale 1ns/10ps
`default_nettype none

module tca_datapath (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Decoder request
  input  wire tca_pkg::tca_req_t req,
  // Datapath state
  output var  tca_pkg::tca_stat_t stat
);

  // Architectural state and its next values
  logic [`TCA_WIDTH-1:0] acc_q;
  logic [`TCA_WIDTH-1:0] acc_d;
  logic                  carry_q;
  logic                  carry_d;
  logic                  ovf_q;
  logic                  ovf_d;
  logic [`TCA_WIDTH-1:0] addend;
  logic [`TCA_WIDTH:0]   sum;
  logic                  add_ovf;
  logic                  is_add;
  logic                  is_inc;
  // Operation strobes from the decoder
  logic                  is_load;
  logic                  is_inv_acc;
  logic                  is_cci_acc;
  logic                  is_inv_ext;
  logic                  is_cci_ext;
  logic                  is_idle;

  // Full adder of the width plus one carry position
  function automatic logic [`TCA_WIDTH:0] add_w(
    input logic [`TCA_WIDTH-1:0] a,
    input logic [`TCA_WIDTH-1:0] b
  );
    add_w = {1'b0, a} + {1'b0, b};
  endfunction

  // ************************************************************
  // Operation decode
  // ************************************************************
  // One strobe per operation; a refused request raises only is_idle
  assign is_add     = req.valid && (req.op == tca_pkg::TCA_OP_ADD);
  assign is_inc     = req.valid && (req.op == tca_pkg::TCA_OP_INCREMENT);
  assign is_load    = req.valid && (req.op == tca_pkg::TCA_OP_LOAD);
  assign is_inv_acc = req.valid &&
    (req.op == tca_pkg::TCA_OP_INVERT_ACCUMULATOR);
  assign is_cci_acc = req.valid &&
    (req.op == tca_pkg::TCA_OP_CLEAR_THEN_INVERT_ACCUMULATOR);
  assign is_inv_ext = req.valid &&
    (req.op == tca_pkg::TCA_OP_INVERT_CARRY_BIT);
  assign is_cci_ext = req.valid &&
    (req.op == tca_pkg::TCA_OP_CLEAR_THEN_INVERT_CARRY_BIT);
  assign is_idle    = !req.valid || (req.op == tca_pkg::TCA_OP_NONE);

  // ************************************************************
  // Adder and operand selection
  // ************************************************************
  assign addend  = is_inc ? `TCA_ONE : req.operand;
  // Sign bit added like any data bit; only one adder exists
  assign sum     = add_w(acc_q, addend);
  // Overflow compares the operand signs with the sign of the sum
  assign add_ovf = (acc_q[`TCA_SIGN_BIT] == addend[`TCA_SIGN_BIT]) &&
                   (sum[`TCA_SIGN_BIT] != acc_q[`TCA_SIGN_BIT]);

  // Next state selection
  always_comb begin
    acc_d   = acc_q;
    carry_d = carry_q;
    ovf_d   = ovf_q;
    // Nothing changes unless a valid request is presented
    if (req.valid) begin
      case (req.op)
        tca_pkg::TCA_OP_LOAD: begin
          acc_d = req.operand;
        end
        tca_pkg::TCA_OP_ADD,
        tca_pkg::TCA_OP_INCREMENT: begin
          // Low 16 bits kept, top carry to extend
          // Extend is never cleared here; without a carry out it keeps its
          // value, and only reset or a complement clears it
          acc_d = sum[`TCA_WIDTH-1:0];
          if (sum[`TCA_WIDTH]) begin
            carry_d = 1'b1;
          end
          ovf_d = add_ovf;
        end
        tca_pkg::TCA_OP_INVERT_ACCUMULATOR: begin
          acc_d = ~acc_q;
        end
        tca_pkg::TCA_OP_CLEAR_THEN_INVERT_ACCUMULATOR: begin
          acc_d = ~`TCA_ACC_RST;
        end
        tca_pkg::TCA_OP_INVERT_CARRY_BIT: begin
          carry_d = ~carry_q;
        end
        tca_pkg::TCA_OP_CLEAR_THEN_INVERT_CARRY_BIT: begin
          carry_d = ~`TCA_EXT_RST;
        end
        default: begin
          acc_d = acc_q;
        end
      endcase
    end
  end

  // ************************************************************
  // State registers
  // ************************************************************
  // Synchronous reset clears accumulator, extend and overflow
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q   <= `TCA_ACC_RST;
      carry_q <= `TCA_EXT_RST;
      ovf_q   <= `TCA_OVF_RST;
    end else begin
      acc_q   <= acc_d;
      carry_q <= carry_d;
      ovf_q   <= ovf_d;
    end
  end

  // Outputs straight from flip-flops
  assign stat.acc      = acc_q;
  assign stat.carry    = carry_q;
  assign stat.overflow = ovf_q;
  assign stat.negative = acc_q[`TCA_SIGN_BIT];

  // ************************************************************
  // Checks: adder
  // ************************************************************
  // Sum wraps at the register width; the 17th bit is not kept
  add_sum_a: assert property (@(posedge clk) disable iff (rst)
    is_add |=> acc_q == $past(acc_q) + $past(req.operand))
    else $error("add result wrong");
  // Increment adds exactly one with the same wrap
  inc_sum_a: assert property (@(posedge clk) disable iff (rst)
    is_inc |=> acc_q == $past(acc_q) + `TCA_ONE)
    else $error("increment result wrong");
  // A wrapped result means a carry out; extend is set, never cleared
  add_carry_a: assert property (@(posedge clk) disable iff (rst)
    is_add || is_inc
    |=> carry_q == ($past(carry_q) || (acc_q < $past(acc_q))))
    else $error("carry not sent to extend");
  // Sign of a sum without overflow follows the true signed sum
  sign_sum_a: assert property (@(posedge clk) disable iff (rst)
    is_add |=> ovf_q || (acc_q[`TCA_SIGN_BIT] ==
      (($signed($past(acc_q)) + $signed($past(req.operand))) < 0)))
    else $error("result sign wrong");
  // Overflow: equal operand signs and a result sign that differs
  ovf_set_a: assert property (@(posedge clk) disable iff (rst)
    is_add || is_inc
    |=> ovf_q == (($past(acc_q[`TCA_SIGN_BIT]) ==
                   $past(addend[`TCA_SIGN_BIT])) &&
                  (acc_q[`TCA_SIGN_BIT] != $past(acc_q[`TCA_SIGN_BIT]))))
    else $error("overflow flag wrong");

  // ************************************************************
  // Checks: complements and negation
  // ************************************************************
  // Every bit of the accumulator flips
  inv_acc_a: assert property (@(posedge clk) disable iff (rst)
    is_inv_acc |=> acc_q == ~$past(acc_q))
    else $error("invert accumulator wrong");
  // The extend bit flips
  inv_ext_a: assert property (@(posedge clk) disable iff (rst)
    is_inv_ext |=> carry_q != $past(carry_q))
    else $error("invert extend wrong");
  // Clear then invert leaves all ones
  cci_acc_a: assert property (@(posedge clk) disable iff (rst)
    is_cci_acc |=> &acc_q)
    else $error("clear invert accumulator wrong");
  // Clear then invert leaves the extend bit set
  cci_ext_a: assert property (@(posedge clk) disable iff (rst)
    is_cci_ext |=> carry_q)
    else $error("clear invert extend wrong");
  // Complement then increment gives the negated value
  neg_pair_a: assert property (@(posedge clk) disable iff (rst)
    is_inv_acc ##1 is_inc |=> acc_q == 16'h0000 - $past(acc_q, 2))
    else $error("negation wrong");

  // ************************************************************
  // Checks: flags and refused requests
  // ************************************************************
  // The negative flag shows the sign bit of a loaded value
  sign_flag_a: assert property (@(posedge clk) disable iff (rst)
    is_load |=> stat.negative == $past(req.operand[`TCA_SIGN_BIT]))
    else $error("sign flag wrong");
  // Operations other than add and increment leave overflow alone
  ovf_hold_a: assert property (@(posedge clk) disable iff (rst)
    req.valid && !is_add && !is_inc |=> $stable(ovf_q))
    else $error("overflow flag changed");
  // A refused request changes no state
  idle_hold_a: assert property (@(posedge clk) disable iff (rst)
    is_idle |=> $stable(acc_q) && $stable(carry_q) && $stable(ovf_q))
    else $error("refused request changed state");

endmodule

`default_nettype wire

// ---- tb/tca_dec_model.sv ----
/* Decoder stand-in: issues one request at a time to the datapath.
   Assumes the bench calls one task at a time; each waits for an edge. */
`timescale 1ns/10ps
`default_nettype none
module tca_dec_model (
  // Clock
  input  wire logic              clk,
  // Request to the datapath
  output var  tca_pkg::tca_req_t req
);
  // Idle: no request, operand does not keep the old value
  initial req = {1'b0, tca_pkg::TCA_OP_NONE, 16'hA5A5};
  // One request held across exactly one taking edge; on release the
  // operation stays with valid low, so an ignored valid shows up
  task automatic issue(input tca_pkg::tca_op_t o, input logic [15:0] d);
    @(posedge clk);
    #1 req = {1'b1, o, d};
    @(posedge clk);
    #1 req = {1'b0, o, ~d};
  endtask
  // Two requests taken at back-to-back edges
  task automatic issue_pair(input tca_pkg::tca_op_t o1,
                            input logic [15:0]      d1,
                            input tca_pkg::tca_op_t o2,
                            input logic [15:0]      d2);
    @(posedge clk);
    #1 req = {1'b1, o1, d1};
    @(posedge clk);
    #1 req = {1'b1, o2, d2};
    @(posedge clk);
    #1 req = {1'b0, o2, ~d2};
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/* Self-checking bench for the accumulator datapath.
   Assumes the decoder model file and the design sources. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  tca_pkg::tca_req_t  req;
  tca_pkg::tca_stat_t stat;
  int                 num_errors = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  tca_dec_model tca_dec_model_inst (.clk(clk), .req(req));
  tca_datapath tca_datapath_inst (.clk(clk), .rst(rst), .req(req),
                                  .stat(stat));
  // Compare one state word
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected state; negative flag follows bit 15
  function automatic logic [18:0] st(input logic [15:0] a, input logic c,
                                     input logic o);
    return {a, c, o, a[15]};
  endfunction
  task automatic op(input tca_pkg::tca_op_t o, input logic [15:0] d);
    tca_dec_model_inst.issue(o, d);
  endtask
  // Complement then increment at back-to-back edges
  task automatic negate();
    tca_dec_model_inst.issue_pair(tca_pkg::TCA_OP_INVERT_ACCUMULATOR,
                                  16'h0000, tca_pkg::TCA_OP_INCREMENT,
                                  16'h0000);
  endtask
  // Negate 07000 octal, then 60000 - 07000
  task automatic t_sub_pos();
    op(tca_pkg::TCA_OP_LOAD, 16'h0E00);
    op(tca_pkg::TCA_OP_INVERT_ACCUMULATOR, 16'h0000);
    chk(stat, st(16'hF1FF, 1'b0, 1'b0));
    op(tca_pkg::TCA_OP_INCREMENT, 16'h0000);
    chk(stat, st(16'hF200, 1'b0, 1'b0));
    op(tca_pkg::TCA_OP_ADD, 16'h6000);
    chk(stat, st(16'h5200, 1'b1, 1'b0));
  endtask
  // Extend bit ops, then -60000 + 07000
  task automatic t_sub_neg();
    op(tca_pkg::TCA_OP_INVERT_CARRY_BIT, 16'h0000);
    chk(stat, st(16'h5200, 1'b0, 1'b0));
    op(tca_pkg::TCA_OP_CLEAR_THEN_INVERT_CARRY_BIT, 16'h0000);
    chk(stat, st(16'h5200, 1'b1, 1'b0));
    op(tca_pkg::TCA_OP_INVERT_CARRY_BIT, 16'h0000);
    op(tca_pkg::TCA_OP_LOAD, 16'h6000);
    negate();
    chk(stat, st(16'hA000, 1'b0, 1'b0));
    op(tca_pkg::TCA_OP_ADD, 16'h0E00);
    chk(stat, st(16'hAE00, 1'b0, 1'b0));
  endtask
  // Overflow, idle and refused requests, wrap of all ones
  task automatic t_ovf();
    op(tca_pkg::TCA_OP_LOAD, 16'h7FFF);
    op(tca_pkg::TCA_OP_ADD, 16'h0001);
    chk(stat, st(16'h8000, 1'b0, 1'b1));
    repeat (3) @(posedge clk);
    op(tca_pkg::TCA_OP_NONE, 16'h1234);
    chk(stat, st(16'h8000, 1'b0, 1'b1));
    op(tca_pkg::TCA_OP_CLEAR_THEN_INVERT_ACCUMULATOR, 16'h0000);
    chk(stat, st(16'hFFFF, 1'b0, 1'b1));
    op(tca_pkg::TCA_OP_INCREMENT, 16'h0000);
    chk(stat, st(16'h0000, 1'b1, 1'b0));
    op(tca_pkg::TCA_OP_LOAD, 16'h8000);
    negate();
    chk(stat, st(16'h8000, 1'b1, 1'b1));
  endtask
  // Reset in mid-run clears a nonzero state
  task automatic t_reset();
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    chk(stat, st(16'h0000, 1'b0, 1'b0));
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    chk(stat, st(16'h0000, 1'b0, 1'b0));
    t_sub_pos();
    t_sub_neg();
    t_ovf();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
